//--- core/fdp_pkg.sv
// Constants, register map and mode encodings of the flexible duplex data port
package fdp_pkg;

   // ***************************************************************
   // Clocking and converter limits
   // ***************************************************************
   localparam int unsigned SYS_CLK_MHZ = 250;
   localparam int unsigned ADC_MAX_MHZ_LO = 50;
   localparam int unsigned ADC_MAX_MHZ_HI = 80;
   localparam logic [7:0] ADC_DIV_MIN_LO = 8'((SYS_CLK_MHZ + ADC_MAX_MHZ_LO - 1) / ADC_MAX_MHZ_LO);
   localparam logic [7:0] ADC_DIV_MIN_HI = 8'((SYS_CLK_MHZ + ADC_MAX_MHZ_HI - 1) / ADC_MAX_MHZ_HI);
   localparam logic [7:0] TX_DIV_MIN = 8'h04;

   // ***************************************************************
   // Bus widths
   // ***************************************************************
   localparam int unsigned BUS_W = 10;
   localparam int unsigned SYNC_BIT = BUS_W - 1;
   localparam logic [9:0] BUS_ALL = 10'h3ff;
   localparam logic [9:0] BUS_NONE = 10'h000;
   localparam logic [9:0] BUS_SYNC_ONLY = 10'h200;

   // ***************************************************************
   // Register map (byte addresses) and fields
   // ***************************************************************
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] ADC_DIV_OFS = 32'h0000_0004;
   localparam logic [31:0] TX_DIV_OFS = 32'h0000_0008;
   localparam logic [31:0] STATUS_OFS = 32'h0000_000c;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_INTERP_LSB = 2;
   localparam int unsigned CTRL_SPEED_BIT = 4;
   localparam logic [4:0] CTRL_RST = 5'h04;
   localparam logic [7:0] ADC_DIV_RST = 8'h08;
   localparam logic [7:0] TX_DIV_RST = 8'h04;
   localparam int unsigned ST_MODE_LSB = 0;
   localparam int unsigned ST_INTERP_LSB = 4;
   localparam int unsigned ST_SERIAL_BIT = 6;
   localparam int unsigned ST_DIR_BIT = 7;
   localparam int unsigned ST_RXPD_BIT = 8;
   localparam int unsigned ST_TXPD_BIT = 9;
   localparam int unsigned ST_COERCE_BIT = 10;

   // ***************************************************************
   // Mode and interpolation encodings
   // ***************************************************************
   localparam logic [1:0] SEL_FULL = 2'h0;
   localparam logic [1:0] SEL_HD_IL = 2'h1;
   localparam logic [1:0] SEL_HD_PAR = 2'h2;
   localparam logic [1:0] SEL_COMPAT = 2'h3;
   localparam logic [1:0] INTERP_1X = 2'h0;
   localparam logic [1:0] INTERP_2X = 2'h1;
   localparam logic [1:0] INTERP_4X = 2'h2;

   typedef enum logic [3:0] {
      FDP_FULL_DUPLEX = 4'h1,
      FDP_HD_INTERLEAVED = 4'h2,
      FDP_HD_PARALLEL = 4'h4,
      FDP_COMPAT = 4'h8
   } fdp_mode_e;

   // ***************************************************************
   // Positions in the synchronised control pin vector
   // ***************************************************************
   localparam int unsigned PIN_DIR = 0;
   localparam int unsigned PIN_PHASE = 1;
   localparam int unsigned PIN_FD = 2;
   localparam int unsigned PIN_INTERP_LSB = 3;
   localparam int unsigned PIN_SERIAL = 5;
   localparam int unsigned PIN_RXPD = 6;
   localparam int unsigned PIN_TXPD = 7;
   localparam int unsigned PIN_N = 8;

endpackage : fdp_pkg

//--- core/fdp_sync2.sv
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module fdp_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk_sys_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_q;
         logic stab_q;
         always_ff @(posedge clk_sys_i) begin
            if (ce_i) begin
               meta_q <= async_i[gi];
               stab_q <= meta_q;
            end
         end
         assign sync_o[gi] = stab_q;
      end
   endgenerate

endmodule : fdp_sync2

//--- core/fdp_clk_div.sv
// Programmable divider giving a period strobe and a mid-period strobe
`timescale 1ns/1ns
module fdp_clk_div (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic en_i,
   input wire logic [7:0] div_i,
   output logic strobe_o,
   output logic half_o
);

   logic [7:0] cnt_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cnt_q <= 8'h00;
      end else if (ce_i) begin
         if (!en_i || cnt_q >= div_i - 8'h01) begin
            cnt_q <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end

   assign strobe_o = en_i && ce_i && (cnt_q == 8'h00);
   assign half_o = en_i && ce_i && (cnt_q == (div_i >> 1));

endmodule : fdp_clk_div

//--- core/fdp_port.sv
// Flexible duplex data port: pin muxing, sample steering and AHB-Lite registers
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
module fdp_port (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [9:0] upper_data_bus_i,
   output logic [9:0] upper_data_bus_o,
   output logic [9:0] upper_data_bus_oe_o,
   input wire logic [9:0] lower_data_bus_i,
   output logic [9:0] lower_data_bus_o,
   output logic [9:0] lower_data_bus_oe_o,
   input wire logic direction_select_pin_i,
   input wire logic rx_channel_phase_pin_i,
   output logic rx_channel_phase_pin_o,
   output logic rx_channel_phase_pin_oe_o,
   output logic data_clock_out_pin_o,
   input wire logic full_duplex_strap_i,
   input wire logic [1:0] interp_strap_i,
   input wire logic serial_port_enable_i,
   input wire logic rx_power_down_pin_i,
   input wire logic tx_power_down_pin_i,
   output logic adc_sample_o,
   input wire logic [9:0] adc_a_i,
   input wire logic [9:0] adc_b_i,
   output logic [9:0] dac_a_o,
   output logic [9:0] dac_b_o,
   output logic dac_valid_o,
   output logic [1:0] dac_interp_o
);

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [fdp_pkg::PIN_N-1:0] pins_raw;
   logic [fdp_pkg::PIN_N-1:0] pins_s;
   logic [19:0] bus_s;
   logic [9:0] upper_s;
   logic [9:0] lower_s;

   assign pins_raw = {tx_power_down_pin_i, rx_power_down_pin_i, serial_port_enable_i,
                      interp_strap_i, full_duplex_strap_i, rx_channel_phase_pin_i,
                      direction_select_pin_i};

   fdp_sync2 #(.WIDTH(fdp_pkg::PIN_N)) u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .ce_i(ce_i),
      .async_i(pins_raw),
      .sync_o(pins_s)
   );

   fdp_sync2 #(.WIDTH(20)) u_bus_sync (
      .clk_sys_i(clk_sys_i),
      .ce_i(ce_i),
      .async_i({upper_data_bus_i, lower_data_bus_i}),
      .sync_o(bus_s)
   );

   assign upper_s = bus_s[19:10];
   assign lower_s = bus_s[9:0];

   // ***************************************************************
   // Strap capture at reset release
   // ***************************************************************
   logic strap_pend_q;
   logic serial_en_q;
   logic fd_strap_q;
   logic width_strap_q;
   logic [1:0] interp_strap_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         strap_pend_q <= 1'b1;
         serial_en_q <= 1'b0;
         fd_strap_q <= 1'b0;
         width_strap_q <= 1'b0;
         interp_strap_q <= fdp_pkg::INTERP_2X;
      end else if (ce_i && strap_pend_q) begin
         strap_pend_q <= 1'b0;
         serial_en_q <= pins_s[fdp_pkg::PIN_SERIAL];
         fd_strap_q <= pins_s[fdp_pkg::PIN_FD];
         width_strap_q <= pins_s[fdp_pkg::PIN_PHASE];
         interp_strap_q <= pins_s[fdp_pkg::PIN_INTERP_LSB +: 2];
      end
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [4:0] ctrl_q;
   logic [7:0] adc_div_q;
   logic [7:0] tx_div_q;
   logic wr_pend_q;
   logic [31:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   logic [31:0] status;
   logic addr_ph;

   assign addr_ph = ce_i && hsel_i && htrans_i[1] && hready_i;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
      end else if (ce_i) begin
         wr_pend_q <= addr_ph && hwrite_i;
         if (addr_ph) begin
            wr_addr_q <= haddr_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ctrl_q <= fdp_pkg::CTRL_RST;
         adc_div_q <= fdp_pkg::ADC_DIV_RST;
         tx_div_q <= fdp_pkg::TX_DIV_RST;
      end else if (ce_i && wr_pend_q) begin
         unique case (wr_addr_q)
            fdp_pkg::CTRL_OFS: ctrl_q <= hwdata_i[4:0];
            fdp_pkg::ADC_DIV_OFS: adc_div_q <= hwdata_i[7:0];
            fdp_pkg::TX_DIV_OFS: tx_div_q <= hwdata_i[7:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   always_comb begin
      unique case (haddr_i)
         fdp_pkg::CTRL_OFS: rd_mux = {27'h0, ctrl_q};
         fdp_pkg::ADC_DIV_OFS: rd_mux = {24'h0, adc_div_q};
         fdp_pkg::TX_DIV_OFS: rd_mux = {24'h0, tx_div_q};
         fdp_pkg::STATUS_OFS: rd_mux = status;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         hrdata_q <= 32'h0000_0000;
      end else if (addr_ph && !hwrite_i) begin
         hrdata_q <= rd_mux;
      end
   end

   assign hrdata_o = hrdata_q;
   assign hreadyout_o = ce_i;
   assign hresp_o = 1'b0;

   // ***************************************************************
   // Mode and interpolation resolution
   // ***************************************************************
   fdp_pkg::fdp_mode_e mode;
   logic [1:0] mode_sel;
   logic [1:0] interp_req;
   logic [1:0] interp_eff;
   logic coerced;
   logic speed_hi;
   logic dir_s;
   logic rx_pd_s;
   logic tx_pd_s;
   logic is_fd;
   logic is_half_duplex_interleaved_mode;
   logic is_half_duplex_parallel_mode;
   logic is_compat;

   assign speed_hi = ctrl_q[fdp_pkg::CTRL_SPEED_BIT];
   assign dir_s = pins_s[fdp_pkg::PIN_DIR];
   assign rx_pd_s = pins_s[fdp_pkg::PIN_RXPD];
   assign tx_pd_s = pins_s[fdp_pkg::PIN_TXPD];

   always_comb begin
      if (serial_en_q) begin
         mode_sel = ctrl_q[fdp_pkg::CTRL_MODE_LSB +: 2];
         interp_req = ctrl_q[fdp_pkg::CTRL_INTERP_LSB +: 2];
      end else if (fd_strap_q) begin
         mode_sel = fdp_pkg::SEL_FULL;
         interp_req = interp_strap_q;
      end else begin
         mode_sel = width_strap_q ? fdp_pkg::SEL_HD_IL : fdp_pkg::SEL_HD_PAR;
         interp_req = interp_strap_q;
      end
   end

   always_comb begin
      unique case (mode_sel)
         fdp_pkg::SEL_FULL: mode = fdp_pkg::FDP_FULL_DUPLEX;
         fdp_pkg::SEL_HD_IL: mode = fdp_pkg::FDP_HD_INTERLEAVED;
         fdp_pkg::SEL_HD_PAR: mode = fdp_pkg::FDP_HD_PARALLEL;
         fdp_pkg::SEL_COMPAT: mode = fdp_pkg::FDP_COMPAT;
      endcase
   end

   assign is_fd = (mode == fdp_pkg::FDP_FULL_DUPLEX);
   assign is_half_duplex_interleaved_mode = (mode == fdp_pkg::FDP_HD_INTERLEAVED);
   assign is_half_duplex_parallel_mode = (mode == fdp_pkg::FDP_HD_PARALLEL);
   assign is_compat = (mode == fdp_pkg::FDP_COMPAT);

   always_comb begin
      interp_eff = interp_req;
      coerced = 1'b0;
      if (interp_req == 2'h3 || (!is_half_duplex_parallel_mode && interp_req == fdp_pkg::INTERP_1X)) begin
         interp_eff = fdp_pkg::INTERP_2X;
         coerced = 1'b1;
      end
   end

   assign dac_interp_o = interp_eff;
   assign status = {21'h0, coerced, tx_pd_s, rx_pd_s, dir_s, serial_en_q, interp_eff, mode};

   // ***************************************************************
   // Path enables and dividers
   // ***************************************************************
   logic rx_act;
   logic tx_act;
   logic rx_il;
   logic tx_il;
   logic [7:0] adc_div_min;
   logic [7:0] adc_div_eff;
   logic [7:0] tx_div_eff;
   logic rx_stb;
   logic rx_half;
   logic tx_stb;

   // Paths stay idle until the straps are latched, so no word moves in a stale mode
   assign rx_act = !strap_pend_q && (is_fd || !dir_s) && !rx_pd_s;
   assign tx_act = !strap_pend_q && (is_fd || dir_s) && !tx_pd_s;
   assign rx_il = is_fd || is_half_duplex_interleaved_mode;
   assign tx_il = !is_half_duplex_parallel_mode;
   assign adc_div_min = speed_hi ? fdp_pkg::ADC_DIV_MIN_HI : fdp_pkg::ADC_DIV_MIN_LO;
   assign adc_div_eff = (adc_div_q < adc_div_min) ? adc_div_min : adc_div_q;
   assign tx_div_eff = (tx_div_q < fdp_pkg::TX_DIV_MIN) ? fdp_pkg::TX_DIV_MIN : tx_div_q;

   fdp_clk_div u_rx_div (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .en_i(rx_act),
      .div_i(adc_div_eff),
      .strobe_o(rx_stb),
      .half_o(rx_half)
   );

   fdp_clk_div u_tx_div (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .en_i(tx_act),
      .div_i(tx_div_eff),
      .strobe_o(tx_stb),
      .half_o()
   );

   assign adc_sample_o = rx_stb;

   // ***************************************************************
   // Receive steering
   // ***************************************************************
   logic [9:0] lower_q;
   logic [9:0] upper_q;
   logic [9:0] b_hold_q;
   logic phase_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         lower_q <= 10'h000;
         upper_q <= 10'h000;
         b_hold_q <= 10'h000;
         phase_q <= 1'b0;
      end else if (ce_i) begin
         if (rx_stb) begin
            b_hold_q <= adc_b_i;
            lower_q <= adc_a_i;
            if (rx_il) begin
               phase_q <= 1'b0;
               upper_q <= fdp_pkg::BUS_NONE;
            end else begin
               upper_q <= adc_b_i;
            end
         end else if (rx_half && rx_il) begin
            lower_q <= b_hold_q;
            phase_q <= 1'b1;
            upper_q <= fdp_pkg::BUS_SYNC_ONLY;
         end
      end
   end

   assign lower_data_bus_o = lower_q;
   assign upper_data_bus_o = upper_q;
   assign rx_channel_phase_pin_o = phase_q;

   // ***************************************************************
   // Transmit steering
   // ***************************************************************
   logic tx_sync;
   logic a_have_q;
   logic [9:0] a_hold_q;
   logic [9:0] dac_a_q;
   logic [9:0] dac_b_q;
   logic dac_valid_q;

   assign tx_sync = is_fd ? dir_s : lower_s[fdp_pkg::SYNC_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         a_have_q <= 1'b0;
         a_hold_q <= 10'h000;
         dac_a_q <= 10'h000;
         dac_b_q <= 10'h000;
         dac_valid_q <= 1'b0;
      end else if (ce_i) begin
         dac_valid_q <= 1'b0;
         if (tx_stb && tx_il) begin
            if (tx_sync) begin
               a_hold_q <= upper_s;
               a_have_q <= 1'b1;
            end else if (a_have_q) begin
               dac_a_q <= a_hold_q;
               dac_b_q <= upper_s;
               dac_valid_q <= 1'b1;
               a_have_q <= 1'b0;
            end
         end else if (tx_stb) begin
            dac_a_q <= upper_s;
            dac_b_q <= lower_s;
            dac_valid_q <= 1'b1;
         end
      end
   end

   assign dac_a_o = dac_a_q;
   assign dac_b_o = dac_b_q;
   assign dac_valid_o = dac_valid_q;

   // ***************************************************************
   // Data clock and bus direction
   // ***************************************************************
   logic dclk_q;
   logic [9:0] upper_oe_q;
   logic [9:0] lower_oe_q;
   logic phase_oe_q;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         dclk_q <= 1'b0;
      end else if (ce_i) begin
         if (is_fd || dir_s) begin
            dclk_q <= tx_stb;
         end else begin
            dclk_q <= rx_stb || (rx_half && rx_il);
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         upper_oe_q <= fdp_pkg::BUS_NONE;
         lower_oe_q <= fdp_pkg::BUS_NONE;
         phase_oe_q <= 1'b0;
      end else if (ce_i) begin
         phase_oe_q <= is_fd;
         if (is_fd) begin
            upper_oe_q <= fdp_pkg::BUS_NONE;
            lower_oe_q <= fdp_pkg::BUS_ALL;
         end else if (dir_s) begin
            upper_oe_q <= fdp_pkg::BUS_NONE;
            lower_oe_q <= fdp_pkg::BUS_NONE;
         end else begin
            upper_oe_q <= is_half_duplex_interleaved_mode ? fdp_pkg::BUS_SYNC_ONLY : fdp_pkg::BUS_ALL;
            lower_oe_q <= fdp_pkg::BUS_ALL;
         end
      end
   end

   assign data_clock_out_pin_o = dclk_q;
   assign upper_data_bus_oe_o = upper_oe_q;
   assign lower_data_bus_oe_o = lower_oe_q;
   assign rx_channel_phase_pin_oe_o = phase_oe_q;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i || !ce_i);

   sequence s_tx_a_word;
      tx_stb && tx_il && tx_sync;
   endsequence

   sequence s_tx_b_word;
      tx_stb && tx_il && !tx_sync && a_have_q;
   endsequence

   a_fd_bus_dir: assert property (is_fd ##1 is_fd |-> lower_data_bus_oe_o == 10'h3ff && upper_data_bus_oe_o == 10'h000) else $error("full duplex bus direction wrong");
   a_pd_no_dac: assert property (tx_pd_s ##1 tx_pd_s |-> !dac_valid_o) else $error("dac strobe while tx powered down");
   a_interp_min: assert property (!is_half_duplex_parallel_mode |-> interp_eff != 2'h0) else $error("1x interpolation outside parallel mode");
   a_interp_par: assert property (is_half_duplex_parallel_mode && interp_req != 2'h3 |-> interp_eff == interp_req) else $error("parallel interpolation altered");
   a_tx_pairing: assert property (s_tx_a_word ##4 s_tx_b_word |=> dac_valid_o &&
      dac_a_o == $past(upper_s, 5) && dac_b_o == $past(upper_s))
      else $error("interleaved pair not emitted");
   a_fd_tx_clk: assert property (is_fd && tx_stb |=> data_clock_out_pin_o ##1 !data_clock_out_pin_o) else $error("tx clock edge missing");
   a_rx_phase: assert property (rx_il && rx_stb |=> lower_data_bus_o == $past(adc_a_i) && !rx_channel_phase_pin_o) else $error("channel A word or phase wrong");
   a_adc_div: assert property (adc_div_eff >= (speed_hi ? 8'h04 : 8'h05)) else $error("ADC clock above limit");
   a_half_duplex_interleaved_mode_rx_oe: assert property (is_half_duplex_interleaved_mode && !dir_s ##1 is_half_duplex_interleaved_mode && !dir_s |-> upper_data_bus_oe_o == 10'h200) else $error("unused bus not three-stated");
   a_par_rx: assert property (!rx_il && rx_stb |=> upper_data_bus_o == $past(adc_b_i) && lower_data_bus_o == $past(adc_a_i)) else $error("parallel rx steering wrong");
   a_no_strap_compat: assert property (!serial_en_q |-> !is_compat) else $error("compat mode from straps");

endmodule : fdp_port

//--- sim/fdp_bb_model.sv
// Baseband partner model presenting interleaved transmit words
`timescale 1ns/1ns
module fdp_bb_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic dclk_i,
   input wire logic [9:0] word_a_i,
   input wire logic [9:0] word_b_i,
   output logic [9:0] bus_o,
   output logic sync_o
);
   logic b_q;
   // Next word only after a data clock pulse, so the rate never exceeds the port's
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) b_q <= 1'h0;
      else if (dclk_i) b_q <= !b_q;
   end
   assign sync_o = !b_q;
   assign bus_o = b_q ? word_b_i : word_a_i;
endmodule : fdp_bb_model

//--- sim/test_flexible_duplex_data_port.sv
// Self-checking bench of the flexible duplex data port
`timescale 1ns/1ns
module test_flexible_duplex_data_port;
   logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, dir = 1'h0;
   logic fd = 1'h1, ser = 1'h0, sel_sync = 1'h1, pd = 1'h0;
   logic [1:0] htrans = 2'h0, ip_o;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hrdy, hresp, dclk, adc_s, dac_v, ph_o, ph_oe, bb_sync;
   logic [9:0] up_i, up_o, up_oe, lo_i, lo_o, lo_oe, dac_a, dac_b, bb_bus;
   int n_mismatch = 0;
   int total_checks = 0;
   localparam logic [9:0] RA = 10'h155, RB = 10'h2aa, TA = 10'h1a5, TB = 10'h05a;
   always #2 clk = ~clk;
   assign up_i = (up_oe & up_o) | (~up_oe & bb_bus);
   // Released lower bits read back inverted so stale values never pass
   assign lo_i = lo_o ^ ~lo_oe;
   fdp_port i_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(1'h1), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .upper_data_bus_i(up_i), .upper_data_bus_o(up_o), .upper_data_bus_oe_o(up_oe),
      .lower_data_bus_i(lo_i), .lower_data_bus_o(lo_o), .lower_data_bus_oe_o(lo_oe),
      .direction_select_pin_i(sel_sync ? bb_sync : dir),
      .rx_channel_phase_pin_i(ph_oe ? ph_o : 1'h0), .rx_channel_phase_pin_o(ph_o),
      .rx_channel_phase_pin_oe_o(ph_oe), .data_clock_out_pin_o(dclk),
      .full_duplex_strap_i(fd), .interp_strap_i(2'h0), .serial_port_enable_i(ser),
      .rx_power_down_pin_i(pd), .tx_power_down_pin_i(pd), .adc_sample_o(adc_s),
      .adc_a_i(RA), .adc_b_i(RB), .dac_a_o(dac_a), .dac_b_o(dac_b), .dac_valid_o(dac_v),
      .dac_interp_o(ip_o));
   fdp_bb_model i_bb (.clk_i(clk), .rst_n_i(rst_n), .dclk_i(dclk), .word_a_i(TA),
      .word_b_i(TB), .bus_o(bb_bus), .sync_o(bb_sync));
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         $display("BAD %s exp %h got %h", nm, e, s);
         n_mismatch++;
      end
   endtask : chk
   task wt(input int k);
      for (int i = 0; i < 300; i++) begin
         @(negedge clk);
         if ((k == 0 ? adc_s : k == 1 ? dac_v : hrdy) === 1'h1) return;
      end
      n_mismatch++;
      test_done();
   endtask : wt
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wt(2);
      @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      wt(2);
      @(posedge clk);
      rd = hrdata;
   endtask : bus
   task reset(input logic s);
      @(posedge clk);
      rst_n <= 1'h0;
      ser <= s;
      fd <= !s;
      sel_sync <= !s;
      pd <= 1'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk);
   endtask : reset
   task fd_rx;
      reset(1'h0);
      bus(1'h0, 32'hc, 32'h0);
      chk("mode", 32'h1, 32'(rd[3:0]));
      chk("interp", 32'h1, 32'(ip_o));
      chk("hresp", 32'h0, 32'(hresp));
      chk("oe", 32'hffc00, 32'({lo_oe, up_oe}));
      wt(0);
      @(negedge clk);
      chk("rx_a", 32'({RA, 1'h0}), 32'({lo_o, ph_o}));
      repeat (5) @(negedge clk);
      chk("rx_b", 32'({RB, 1'h1}), 32'({lo_o, ph_o}));
   endtask : fd_rx
   task fd_tx;
      wt(1);
      chk("dac", 32'({TA, TB, 1'h1}), 32'({dac_a, dac_b, dclk}));
      @(posedge clk);
      pd <= 1'h1;
      repeat (4) @(negedge clk);
      repeat (10) begin
         @(negedge clk);
         chk("pd", 32'h0, 32'({adc_s, dac_v}));
      end
   endtask : fd_tx
   task hd_par;
      reset(1'h1);
      bus(1'h1, 32'h0, 32'h2);
      bus(1'h0, 32'hc, 32'h0);
      chk("status", 32'h44, 32'(rd[6:0]));
      chk("oe", 32'hfffff, 32'({up_oe, lo_oe}));
      wt(0);
      @(negedge clk);
      chk("rx", 32'({RB, RA}), 32'({up_o, lo_o}));
      bus(1'h0, 32'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'h1, 32'h4, 32'h2);
      wt(0);
      repeat (fdp_pkg::ADC_DIV_MIN_LO - 8'h01) begin
         @(negedge clk);
         chk("rx_gap", 32'h0, 32'(adc_s));
      end
      @(negedge clk);
      chk("rx_rate", 32'h1, 32'(adc_s));
      @(posedge clk);
      dir <= 1'h1;
      repeat (6) @(negedge clk);
      chk("oe_tx", 32'h0, 32'({up_oe, lo_oe}));
      wt(1);
      chk("par_tx", 32'({bb_bus, ~RA}), 32'({dac_a, dac_b}));
      @(posedge clk);
      dir <= 1'h0;
      bus(1'h1, 32'h0, 32'h5);
      repeat (2) @(negedge clk);
      chk("half_duplex_interleaved_mode_oe", 32'({10'h200, 10'h3ff}), 32'({up_oe, lo_oe}));
      wt(0);
      @(negedge clk);
      chk("half_duplex_interleaved_mode_a", 32'({1'h0, RA}), 32'({up_o[9], lo_o}));
      repeat (3) @(negedge clk);
      chk("half_duplex_interleaved_mode_b", 32'({1'h1, RB}), 32'({up_o[9], lo_o}));
      bus(1'h1, 32'h0, 32'h7);
      wt(0);
      @(negedge clk);
      chk("compat_rx", 32'({RB, RA}), 32'({up_o, lo_o}));
   endtask : hd_par
   initial begin
      fd_rx();
      fd_tx();
      hd_par();
      test_done();
   end
endmodule : test_flexible_duplex_data_port
